// >>> include/tle_pkg.sv
// Constants, field positions and carrier types for the trace and TLB miss exception unit.
// Assumes a single core clock and big-endian bit numbering, bit 0 being the most significant.
// How it works
// - Single-step on: trace after each clean completion, except return-from-interrupt.
// - Instruction-synchronize never raises a single-step trace exception.
// - Branch trace on: trace after every clean branch completion.
// - System call, taken trap or any other exception never traces.
// - Taking a trace clears single-step and branch-trace enables.
// - Trace saves address of the instruction after the traced one.
// - Trace: saved status 0-15 cleared, 16-31 copied from machine state.
// - Trace clears doze, shadow, user, float, trace, translation, recoverable; byte order from handler.
// - Soft stop enabled: trace or breakpoint condition halts instead of trapping.
// - Breakpoint beats trace when both occur together.
// - Trace handler starts at 0x00D00 above the selected vector base.
// - Only the debug processor enables soft stop; halt is restartable by it.
// - Soft stop halts with restartable set; branch hard stop halts at once with it clear; a restart resumes either.
// - Instruction translation miss raises exception at offset 0x01000.
// - Data load translation miss raises exception at offset 0x01100.
// - TLB miss saves address of next instruction to execute.
// - TLB miss: status 0-3 from condition field, 4-12 cleared, 16-31 copied.
// - Status bit 13 is 1 for instruction miss, 0 for data miss.
// - Status bit 14 reports associativity set to replace.
// - Status bit 15 is 1 for load miss, 0 for store or changed-bit.
// - TLB miss sets shadow select, clears doze, enables, user, float, trace, translation.
package tle_pkg;

   // Machine state bit positions
   localparam int BIT_DOZE = 13;
   localparam int BIT_SHADOW = 14;
   localparam int BIT_HBO = 15;
   localparam int BIT_EE = 16;
   localparam int BIT_PR = 17;
   localparam int BIT_FP = 18;
   localparam int BIT_ME = 19;
   localparam int BIT_FE0 = 20;
   localparam int BIT_SE = 21;
   localparam int BIT_BE = 22;
   localparam int BIT_FE1 = 23;
   localparam int BIT_VBH = 25;
   localparam int BIT_IR = 26;
   localparam int BIT_DR = 27;
   localparam int BIT_RI = 30;
   localparam int BIT_BO = 31;

   // Vector bases and handler offsets
   localparam logic [31:0] BASE_LOW = 32'h0000_0000;
   localparam logic [31:0] BASE_HIGH = 32'hFFF0_0000;
   localparam logic [31:0] OFS_TRACE = 32'h0000_0D00;
   localparam logic [31:0] OFS_INSTRUCTION_TRANSLATION_BUFFER = 32'h0000_1000;
   localparam logic [31:0] OFS_DATA_TRANSLATION_BUFFER_LD = 32'h0000_1100;

   // Reset values
   localparam logic [0:31] MSR_RST = 32'h0000_0000;
   localparam logic [2:0] DBG_RST = 3'h0;

   typedef enum logic [1:0] {
      KIND_NONE = 2'b00,
      KIND_TRACE = 2'b01,
      KIND_INSTRUCTION_TRANSLATION_BUFFER = 2'b10,
      KIND_DATA_TRANSLATION_BUFFER_LD = 2'b11
   } tle_kind_e;

   typedef enum logic [1:0] {
      RUN_GO = 2'b00,
      RUN_SOFT = 2'b01,
      RUN_HARD = 2'b10
   } tle_run_e;

   typedef struct packed {
      logic valid;
      logic [31:0] next_pc;
      logic is_branch;
      logic is_rfi;
      logic is_isync;
      logic is_sc;
      logic trap_taken;
      logic other_exc;
      logic higher_pend;
      logic bkpt_hit;
   } tle_compl_s;

   typedef struct packed {
      logic instruction_translation_buffer_miss;
      logic data_translation_buffer_load_miss;
      logic replace_set;
      logic [31:0] next_pc;
      logic [0:3] cond_zero;
   } tle_tlb_s;

   typedef struct packed {
      logic valid;
      logic [0:31] value;
   } tle_msr_wr_s;

   typedef struct packed {
      logic soft_stop;
      logic hard_stop;
      logic restart;
   } tle_dbg_s;

   typedef struct packed {
      logic valid;
      tle_kind_e kind;
      logic [31:0] vector;
   } tle_exc_s;

   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [2:0] s3;
      logic [2:0] q;
   } tle_sync_s;

   typedef struct packed {
      tle_run_e run;
      logic halted;
      logic restartable;
      logic [0:31] machine_state_reg;
      logic [31:0] save_restore_pc;
      logic [0:31] save_restore_status;
      tle_exc_s exc;
      logic restart_seen;
   } tle_state_s;

endpackage : tle_pkg

// >>> verilog/tle_dbg_sync.sv
// Three-flop synchroniser for the debug control pins.
// Assumes pins driven from outside the core clock; a change is taken once stages two and three agree.
`timescale 1ns/10ps
module tle_dbg_sync (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Raw debug pins
   input wire tle_pkg::tle_dbg_s i_pins,
   // Settled debug controls
   output tle_pkg::tle_dbg_s o_ctl
);

   tle_pkg::tle_sync_s st_q;
   tle_pkg::tle_sync_s st_d;
   logic [2:0] agree;

   always_comb begin
      st_d = st_q;
      agree = ~(st_q.s2 ^ st_q.s3);
      st_d.s1 = i_pins;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.q = (agree & st_q.s3) | (~agree & st_q.q);
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         st_q.s1 <= tle_pkg::DBG_RST;
         st_q.s2 <= tle_pkg::DBG_RST;
         st_q.s3 <= tle_pkg::DBG_RST;
         st_q.q <= tle_pkg::DBG_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_ctl = st_q.q;

endmodule : tle_dbg_sync

// >>> verilog/tle_exc_unit.sv
// Trace, instruction TLB miss and data load TLB miss exception unit.
// Assumes the pipeline stalls while o_stall is high and presents one completion per cycle.
`timescale 1ns/10ps
module tle_exc_unit (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Completion pipeline
   input wire tle_pkg::tle_compl_s i_compl,
   input wire tle_pkg::tle_msr_wr_s i_msr_wr,
   // Translation buffers
   input wire tle_pkg::tle_tlb_s i_tlb,
   // Debug port pins from the service processor
   input wire tle_pkg::tle_dbg_s i_dbg,
   // Exception request and saved state
   output tle_pkg::tle_exc_s o_exc,
   output logic [0:31] o_msr,
   output logic [31:0] o_save_restore_pc,
   output logic [0:31] o_save_restore_status,
   // Debug status
   output logic o_halted,
   output logic o_restartable,
   output logic o_stall
);

   tle_pkg::tle_state_s state_q;
   tle_pkg::tle_state_s state_d;
   tle_pkg::tle_dbg_s dbg;
   logic running;
   logic clean;
   logic ss_hit;
   logic bt_hit;
   logic trace_hit;
   logic bkpt_stop;
   logic restart_rise;
   logic [31:0] base;

   tle_dbg_sync u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pins(i_dbg),
      .o_ctl(dbg)
   );

   // Machine state on trace entry
   function automatic logic [0:31] trace_msr(input logic [0:31] m);
      logic [0:31] r;
      r = m;
      r[tle_pkg::BIT_DOZE] = 1'b0;
      r[tle_pkg::BIT_SHADOW] = 1'b0;
      r[tle_pkg::BIT_EE] = 1'b0;
      r[tle_pkg::BIT_PR] = 1'b0;
      r[tle_pkg::BIT_FP] = 1'b0;
      r[tle_pkg::BIT_FE0] = 1'b0;
      r[tle_pkg::BIT_FE1] = 1'b0;
      r[tle_pkg::BIT_SE] = 1'b0;
      r[tle_pkg::BIT_BE] = 1'b0;
      r[tle_pkg::BIT_IR] = 1'b0;
      r[tle_pkg::BIT_DR] = 1'b0;
      r[tle_pkg::BIT_RI] = 1'b0;
      r[tle_pkg::BIT_BO] = m[tle_pkg::BIT_HBO];
      return r;
   endfunction : trace_msr

   // Machine state on TLB miss entry
   function automatic logic [0:31] tlb_msr(input logic [0:31] m);
      logic [0:31] r;
      r = m;
      r[tle_pkg::BIT_DOZE] = 1'b0;
      r[tle_pkg::BIT_SHADOW] = 1'b1;
      r[tle_pkg::BIT_EE] = 1'b0;
      r[tle_pkg::BIT_PR] = 1'b0;
      r[tle_pkg::BIT_FP] = 1'b0;
      r[tle_pkg::BIT_FE0] = 1'b0;
      r[tle_pkg::BIT_FE1] = 1'b0;
      r[tle_pkg::BIT_SE] = 1'b0;
      r[tle_pkg::BIT_BE] = 1'b0;
      r[tle_pkg::BIT_IR] = 1'b0;
      r[tle_pkg::BIT_DR] = 1'b0;
      r[tle_pkg::BIT_RI] = 1'b0;
      r[tle_pkg::BIT_BO] = m[tle_pkg::BIT_HBO];
      return r;
   endfunction : tlb_msr

   always_comb begin
      running = (state_q.run == tle_pkg::RUN_GO);
      base = state_q.machine_state_reg[tle_pkg::BIT_VBH] ? tle_pkg::BASE_HIGH : tle_pkg::BASE_LOW;
      // Clean completion only; breakpoint takes the instruction first
      clean = i_compl.valid & ~i_compl.other_exc & ~i_compl.higher_pend & ~i_compl.is_sc
         & ~i_compl.trap_taken & ~i_compl.bkpt_hit;
      ss_hit = state_q.machine_state_reg[tle_pkg::BIT_SE] & ~i_compl.is_rfi & ~i_compl.is_isync;
      bt_hit = state_q.machine_state_reg[tle_pkg::BIT_BE] & i_compl.is_branch;
      trace_hit = clean & (ss_hit | bt_hit);
      bkpt_stop = i_compl.valid & i_compl.bkpt_hit & dbg.soft_stop;
      restart_rise = dbg.restart & ~state_q.restart_seen;
   end

   always_comb begin
      state_d = state_q;
      state_d.exc.valid = 1'b0;
      state_d.exc.kind = tle_pkg::KIND_NONE;
      state_d.restart_seen = dbg.restart;
      case (state_q.run)
         tle_pkg::RUN_GO: begin
            if (i_tlb.data_translation_buffer_load_miss) begin
               state_d.exc.valid = 1'b1;
               state_d.exc.kind = tle_pkg::KIND_DATA_TRANSLATION_BUFFER_LD;
               state_d.exc.vector = base | tle_pkg::OFS_DATA_TRANSLATION_BUFFER_LD;
               state_d.save_restore_pc = i_tlb.next_pc;
               state_d.save_restore_status = {i_tlb.cond_zero, 9'h000, 1'b0, i_tlb.replace_set, 1'b1,
                  state_q.machine_state_reg[16:31]};
               state_d.machine_state_reg = tlb_msr(state_q.machine_state_reg);
            end else if (i_tlb.instruction_translation_buffer_miss) begin
               state_d.exc.valid = 1'b1;
               state_d.exc.kind = tle_pkg::KIND_INSTRUCTION_TRANSLATION_BUFFER;
               state_d.exc.vector = base | tle_pkg::OFS_INSTRUCTION_TRANSLATION_BUFFER;
               state_d.save_restore_pc = i_tlb.next_pc;
               state_d.save_restore_status = {i_tlb.cond_zero, 9'h000, 1'b1, i_tlb.replace_set, 1'b0,
                  state_q.machine_state_reg[16:31]};
               state_d.machine_state_reg = tlb_msr(state_q.machine_state_reg);
            end else if (trace_hit && bt_hit && dbg.hard_stop) begin
               state_d.run = tle_pkg::RUN_HARD;
               state_d.halted = 1'b1;
               state_d.restartable = 1'b0;
            end else if (trace_hit && dbg.soft_stop) begin
               state_d.run = tle_pkg::RUN_SOFT;
               state_d.halted = 1'b1;
               state_d.restartable = 1'b1;
            end else if (trace_hit) begin
               state_d.exc.valid = 1'b1;
               state_d.exc.kind = tle_pkg::KIND_TRACE;
               state_d.exc.vector = base | tle_pkg::OFS_TRACE;
               state_d.save_restore_pc = i_compl.next_pc;
               state_d.save_restore_status = {16'h0000, state_q.machine_state_reg[16:31]};
               state_d.machine_state_reg = trace_msr(state_q.machine_state_reg);
            end else if (bkpt_stop) begin
               state_d.run = tle_pkg::RUN_SOFT;
               state_d.halted = 1'b1;
               state_d.restartable = 1'b1;
            end else if (i_msr_wr.valid) begin
               state_d.machine_state_reg = i_msr_wr.value;
            end
         end
         tle_pkg::RUN_SOFT, tle_pkg::RUN_HARD: begin
            if (restart_rise) begin
               state_d.run = tle_pkg::RUN_GO;
               state_d.halted = 1'b0;
               state_d.restartable = 1'b0;
            end
         end
         default: begin
            state_d.run = tle_pkg::RUN_GO;
            state_d.halted = 1'b0;
            state_d.restartable = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= '0;
         state_q.machine_state_reg <= tle_pkg::MSR_RST;
      end else begin
         state_q <= state_d;
      end
   end

   assign o_exc = state_q.exc;
   assign o_msr = state_q.machine_state_reg;
   assign o_save_restore_pc = state_q.save_restore_pc;
   assign o_save_restore_status = state_q.save_restore_status;
   assign o_halted = state_q.halted;
   assign o_restartable = state_q.restartable;
   assign o_stall = state_q.halted;

   // Checks
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   logic no_tlb;
   assign no_tlb = ~i_tlb.instruction_translation_buffer_miss & ~i_tlb.data_translation_buffer_load_miss;

   sequence s_trace_trap;
      running && no_tlb && trace_hit && !dbg.soft_stop && !dbg.hard_stop;
   endsequence

   sequence s_trace_out;
      o_exc.valid && o_exc.kind == tle_pkg::KIND_TRACE;
   endsequence

   sequence s_hard_cause;
      running && no_tlb && trace_hit && bt_hit && dbg.hard_stop;
   endsequence

   sequence s_held_halt;
      (o_halted && !o_restartable && !o_exc.valid && o_stall) [*2];
   endsequence

   a_step_trace: assert property (running && no_tlb && clean && i_compl.is_branch == 1'b0
      && ss_hit && !dbg.soft_stop |=> s_trace_out)
      else $error("single step did not trace");

   a_isync_quiet: assert property (i_compl.valid && i_compl.is_isync && !i_compl.is_branch
      |=> !(o_exc.kind == tle_pkg::KIND_TRACE))
      else $error("trace raised on isync");

   a_branch_trace: assert property (s_trace_trap ##0 bt_hit |=> s_trace_out)
      else $error("branch did not trace");

   a_sc_quiet: assert property (i_compl.valid && (i_compl.is_sc || i_compl.trap_taken
      || i_compl.other_exc) |=> !(o_exc.kind == tle_pkg::KIND_TRACE))
      else $error("trace after sc or trap");

   a_trace_msr: assert property (s_trace_out |-> !o_msr[tle_pkg::BIT_SE]
      && !o_msr[tle_pkg::BIT_BE] && !o_msr[tle_pkg::BIT_PR] && !o_msr[tle_pkg::BIT_SHADOW]
      && o_msr[tle_pkg::BIT_BO] == o_msr[tle_pkg::BIT_HBO])
      else $error("trace machine state wrong");

   a_trace_pc: assert property (s_trace_trap |=> o_save_restore_pc == $past(i_compl.next_pc))
      else $error("trace saved pc wrong");

   a_trace_status: assert property (s_trace_trap |=> o_save_restore_status[0:15] == 16'h0000
      && o_save_restore_status[16:31] == $past(state_q.machine_state_reg[16:31]))
      else $error("trace saved status wrong");

   a_soft_halt: assert property (running && no_tlb && (trace_hit || bkpt_stop)
      && dbg.soft_stop && !(bt_hit && dbg.hard_stop)
      |=> o_halted && o_restartable && !o_exc.valid)
      else $error("soft stop not taken");

   a_bkpt_first: assert property (i_compl.valid && i_compl.bkpt_hit
      |=> !(o_exc.kind == tle_pkg::KIND_TRACE))
      else $error("trace beat breakpoint");

   a_trace_vector: assert property (s_trace_trap |=> o_exc.vector
      == ($past(state_q.machine_state_reg[tle_pkg::BIT_VBH]) ? 32'hFFF0_0D00 : 32'h0000_0D00))
      else $error("trace vector wrong");

   a_restart_run: assert property (o_halted && !dbg.restart ##1 dbg.restart
      |=> !o_halted)
      else $error("restart ignored");

   a_hard_halt: assert property (s_hard_cause ##1 !dbg.restart |=> s_held_halt)
      else $error("hard stop not held");

   a_instruction_translation_buffer_vector: assert property (running && i_tlb.instruction_translation_buffer_miss && !i_tlb.data_translation_buffer_load_miss
      |=> o_exc.valid && o_exc.kind == tle_pkg::KIND_INSTRUCTION_TRANSLATION_BUFFER
      && o_exc.vector[15:0] == 16'h1000 && o_save_restore_status[13] && !o_save_restore_status[15])
      else $error("instruction_translation_buffer miss wrong");

   a_data_translation_buffer_vector: assert property (running && i_tlb.data_translation_buffer_load_miss |=> o_exc.valid
      && o_exc.kind == tle_pkg::KIND_DATA_TRANSLATION_BUFFER_LD && o_exc.vector[15:0] == 16'h1100
      && !o_save_restore_status[13] && o_save_restore_status[15])
      else $error("data_translation_buffer load miss wrong");

   a_tlb_pc: assert property (running && !no_tlb |=> o_save_restore_pc == $past(i_tlb.next_pc))
      else $error("tlb saved pc wrong");

   a_tlb_status: assert property (running && !no_tlb |=> o_save_restore_status[0:3] == $past(i_tlb.cond_zero)
      && o_save_restore_status[4:12] == 9'h000 && o_save_restore_status[14] == $past(i_tlb.replace_set)
      && o_save_restore_status[16:31] == $past(state_q.machine_state_reg[16:31]))
      else $error("tlb saved status wrong");

   a_tlb_msr: assert property (running && !no_tlb |=> o_msr[tle_pkg::BIT_SHADOW]
      && !o_msr[tle_pkg::BIT_EE] && !o_msr[tle_pkg::BIT_IR] && !o_msr[tle_pkg::BIT_DOZE]
      && o_msr[tle_pkg::BIT_BO] == o_msr[tle_pkg::BIT_HBO])
      else $error("tlb machine state wrong");

   a_single_trace: assert property (s_trace_trap ##0 (bt_hit && ss_hit)
      ##1 (!i_compl.valid && no_tlb) |=> !o_exc.valid)
      else $error("double trace");

endmodule : tle_exc_unit

// >>> tb/tle_dbg_partner.sv
// Behavioural debug service processor that drives the debug port pins.
// Assumes the bench picks a stop mode and asks for restarts; pins change just after i_clk.
`timescale 1ns/10ps
module tle_dbg_partner (
   // Clock
   input wire logic i_clk,
   // Requests from the bench
   input wire tle_pkg::tle_run_e i_mode,
   input wire logic i_restart_req,
   // Core status
   input wire logic i_halted,
   // Debug port pins
   output tle_pkg::tle_dbg_s o_dbg
);
   initial o_dbg = '0;
   always @(posedge i_clk) begin
      // Stop modes are enabled from this side only
      o_dbg.soft_stop <= (i_mode == tle_pkg::RUN_SOFT);
      o_dbg.hard_stop <= (i_mode == tle_pkg::RUN_HARD);
      // Restart is raised only while the core is halted
      o_dbg.restart <= i_restart_req & i_halted;
   end
endmodule : tle_dbg_partner

// >>> tb/trace_tlb_miss_exceptions_test.sv
// Self-checking bench for the trace and TLB miss exception unit.
// Assumes one core clock; the debug partner model drives the debug pins.
`timescale 1ns/10ps
module trace_tlb_miss_exceptions_test;
   typedef struct packed {
      tle_pkg::tle_kind_e kind;
      logic [31:0] vec;
      logic [31:0] pc;
      logic [0:31] s1;
      logic [0:31] m;
   } tle_note_s;
   logic i_clk;
   logic i_rst;
   tle_pkg::tle_compl_s compl;
   tle_pkg::tle_msr_wr_s mwr;
   tle_pkg::tle_tlb_s tlb;
   tle_pkg::tle_dbg_s dbg;
   tle_pkg::tle_exc_s exc;
   tle_pkg::tle_run_e mode;
   logic rs_req;
   logic [0:31] msr_o;
   logic [31:0] save_restore_pc;
   logic [0:31] save_restore_status;
   logic halted;
   logic restartable;
   logic stall;
   logic [0:31] mdl_msr;
   logic [31:0] seed;
   logic [0:31] v;
   tle_note_s note;
   tle_note_s got;
   tle_note_s notes[$];
   int error_cnt;
   int samples_checked;
   int cycles;
   int i;
   int clr_bits[12] = '{13, 14, 16, 17, 18, 20, 21, 22, 23, 26, 27, 30};

   tle_exc_unit u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_compl(compl), .i_msr_wr(mwr),
      .i_tlb(tlb), .i_dbg(dbg), .o_exc(exc), .o_msr(msr_o), .o_save_restore_pc(save_restore_pc), .o_save_restore_status(save_restore_status),
      .o_halted(halted), .o_restartable(restartable), .o_stall(stall));
   tle_dbg_partner u_esp (.i_clk(i_clk), .i_mode(mode), .i_restart_req(rs_req),
      .i_halted(halted), .o_dbg(dbg));

   initial i_clk = 1'b0;
   always #2 i_clk = ~i_clk;

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic tle_note_s predict(input tle_pkg::tle_kind_e k, input logic [0:31] m,
      input logic [31:0] pc, input logic [0:3] cz, input logic set);
      tle_note_s n;
      logic [31:0] base;
      base = m[tle_pkg::BIT_VBH] ? tle_pkg::BASE_HIGH : tle_pkg::BASE_LOW;
      n.kind = k;
      n.pc = pc;
      n.s1 = 32'h0;
      n.s1[16:31] = m[16:31];
      n.m = m;
      foreach (clr_bits[j]) n.m[clr_bits[j]] = 1'b0;
      n.m[tle_pkg::BIT_BO] = m[tle_pkg::BIT_HBO];
      if (k == tle_pkg::KIND_TRACE) begin
         n.vec = base | tle_pkg::OFS_TRACE;
      end else begin
         n.s1[0:3] = cz;
         n.s1[13] = (k == tle_pkg::KIND_INSTRUCTION_TRANSLATION_BUFFER);
         n.s1[14] = set;
         n.s1[15] = (k == tle_pkg::KIND_DATA_TRANSLATION_BUFFER_LD);
         n.m[tle_pkg::BIT_SHADOW] = 1'b1;
         n.vec = base | ((k == tle_pkg::KIND_INSTRUCTION_TRANSLATION_BUFFER) ? tle_pkg::OFS_INSTRUCTION_TRANSLATION_BUFFER : tle_pkg::OFS_DATA_TRANSLATION_BUFFER_LD);
      end
      return n;
   endfunction : predict

   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      samples_checked++;
      if (g !== e) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         error_cnt++;
      end
   endtask : chk

   task automatic results();
      $display("errors=%0d checks=%0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   task automatic set_msr(input logic [0:31] val);
      @(posedge i_clk);
      mwr <= {1'b1, val};
      @(posedge i_clk);
      mwr <= '0;
      mdl_msr = val;
   endtask : set_msr

   // Flags: branch, rfi, isync, sc, trap, other, higher, breakpoint
   task automatic complete(input logic [7:0] f, input logic trace);
      tle_pkg::tle_compl_s c;
      c = {1'b1, rnd(), f};
      if (trace) begin
         note = predict(tle_pkg::KIND_TRACE, mdl_msr, c.next_pc, 4'h0, 1'b0);
         notes.push_back(note);
         mdl_msr = note.m;
      end
      @(posedge i_clk);
      compl <= c;
      @(posedge i_clk);
      compl <= '0;
      repeat (2) @(posedge i_clk);
      #1;
   endtask : complete

   task automatic miss(input logic instruction_translation_buffer, input logic set);
      tle_pkg::tle_tlb_s t;
      t = {instruction_translation_buffer, ~instruction_translation_buffer, set, rnd(), 4'(rnd())};
      note = predict(instruction_translation_buffer ? tle_pkg::KIND_INSTRUCTION_TRANSLATION_BUFFER : tle_pkg::KIND_DATA_TRANSLATION_BUFFER_LD, mdl_msr, t.next_pc,
         t.cond_zero, set);
      notes.push_back(note);
      mdl_msr = note.m;
      @(posedge i_clk);
      tlb <= t;
      @(posedge i_clk);
      tlb <= '0;
      repeat (2) @(posedge i_clk);
   endtask : miss

   task automatic resume();
      rs_req <= 1'b1;
      for (int k = 0; k < 20 && halted !== 1'b0; k++) @(posedge i_clk);
      #1;
      chk(halted, 64'h0);
      rs_req <= 1'b0;
      @(posedge i_clk);
   endtask : resume

   task automatic done(input string name);
      repeat (3) @(posedge i_clk);
      chk(64'(notes.size()), 64'h0);
      $display("test %s done", name);
   endtask : done

   // Compares each exception against the oldest note
   always @(posedge i_clk) begin
      if (i_rst === 1'b0 && exc.valid === 1'b1) begin
         if (notes.size() == 0) begin
            chk(exc, 64'h0);
         end else begin
            got = notes.pop_front();
            chk(exc.kind, got.kind);
            chk(exc.vector, got.vec);
            chk(save_restore_pc, got.pc);
            chk(save_restore_status, got.s1);
            chk(msr_o, got.m);
         end
      end
   end

   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         error_cnt++;
         results();
      end
   end

   initial begin
      seed = 32'hF706CD74;
      i_rst = 1'b1;
      compl = '0;
      mwr = '0;
      tlb = '0;
      mode = tle_pkg::RUN_GO;
      rs_req = 1'b0;
      mdl_msr = tle_pkg::MSR_RST;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      #1;
      chk(msr_o, tle_pkg::MSR_RST);
      for (i = 0; i < 4; i++) begin
         v = rnd();
         v[tle_pkg::BIT_SE] = 1'b1;
         v[tle_pkg::BIT_BE] = 1'b0;
         set_msr(v);
         complete(8'h00, 1'b1);
         complete(8'h00, 1'b0);
      end
      done("single_step");
      for (i = 0; i < 7; i++) begin
         v = rnd() | 32'h0000_0400;
         set_msr(v);
         complete(8'h40 >> i, 1'b0);
         complete(8'h00, 1'b1);
      end
      done("exclusions");
      v = rnd() & 32'hFFFF_F9FF | 32'h0000_0200;
      set_msr(v);
      complete(8'h00, 1'b0);
      complete(8'h80, 1'b1);
      set_msr(v | 32'h0000_0600);
      complete(8'h80, 1'b1);
      done("branch");
      for (i = 0; i < 4; i++) begin
         set_msr(rnd());
         miss(i[0], i[1]);
      end
      done("tlb_miss");
      mode <= tle_pkg::RUN_SOFT;
      repeat (6) @(posedge i_clk);
      set_msr(rnd() | 32'h0000_0400);
      complete(8'h00, 1'b0);
      chk({halted, restartable, stall}, 64'h7);
      chk(msr_o, mdl_msr);
      complete(8'h00, 1'b0);
      resume();
      set_msr(rnd() & 32'hFFFF_F9FF);
      complete(8'h01, 1'b0);
      chk({halted, restartable}, 64'h3);
      resume();
      mode <= tle_pkg::RUN_GO;
      done("soft_stop");
      mode <= tle_pkg::RUN_HARD;
      repeat (6) @(posedge i_clk);
      set_msr(32'h0000_0200);
      complete(8'h80, 1'b0);
      chk({halted, restartable, stall}, 64'h5);
      mode <= tle_pkg::RUN_GO;
      i_rst <= 1'b1;
      repeat (3) @(posedge i_clk);
      i_rst <= 1'b0;
      mdl_msr = tle_pkg::MSR_RST;
      @(posedge i_clk);
      #1;
      chk({halted, msr_o}, 64'h0);
      done("hard_stop");
      results();
   end
endmodule : trace_tlb_miss_exceptions_test
